/* File: rtl/ffmd_pkg.sv */
// constants shared by the free-fall and high-g motion detector
// How it works
// - the free-fall threshold register sits at index 0x08, read/write, reset 0x0e.
// - the free-fall debounce register sits at index 0x09, read/write, reset 0x01.
// - a serial read uses the index with bit 7 set, a write the plain index.
// - free-fall is declared only when all three axes are below threshold for the debounce count.
// - a threshold step equals 16 axis counts, so 128 steps span mid-scale to either end.
// - each debounce value 1..255 is the number of check samples the condition must persist; 0 acts as 1.
// - the high-g threshold register sits at index 0x0a, read/write, reset 0x55.
// - the high-g debounce register sits at index 0x0b, read/write, reset 0x01.
// - high-g motion is declared when any axis exceeds threshold for the debounce count.
// - both events drive the one shared interrupt output.
// - the two rate bits pick 250 Hz, 1 kHz, 4 kHz or 16 kHz check sampling.
// - no free-fall interrupt is raised while its enable bit is clear.
// - free-fall follows detection, or with latching holds until its enable is cleared.
// - motion follows detection, or with latching holds until the motion enable pin goes low.
package ffmd_pkg;
  localparam logic [6:0] addr_ff_thresh = 7'h08;
  localparam logic [6:0] addr_ff_count = 7'h09;
  localparam logic [6:0] addr_hg_thresh = 7'h0a;
  localparam logic [6:0] addr_hg_count = 7'h0b;
  localparam int read_flag_bit = 7;
  localparam logic [7:0] rst_ff_thresh = 8'h0e;
  localparam logic [7:0] rst_ff_count = 8'h01;
  localparam logic [7:0] rst_hg_thresh = 8'h55;
  localparam logic [7:0] rst_hg_count = 8'h01;
  localparam logic [11:0] mid_scale = 12'h800;
  localparam int clk_hz = 100_000_000;
  localparam int rate0_hz = 250;
  localparam int rate1_hz = 1_000;
  localparam int rate2_hz = 4_000;
  localparam int rate3_hz = 16_000;
  localparam int tick0_cycles = clk_hz / rate0_hz;
  localparam int tick1_cycles = clk_hz / rate1_hz;
  localparam int tick2_cycles = clk_hz / rate2_hz;
  localparam int tick3_cycles = clk_hz / rate3_hz;
endpackage

/* File: rtl/axis_bus_if.sv */
// carrier of one sample tick and the folded axis magnitudes
`timescale 1ns/1ps
interface axis_bus_if;
  logic tick;
  logic [7:0] mag_x;
  logic [7:0] mag_y;
  logic [7:0] mag_z;
  modport src (output tick, output mag_x, output mag_y, output mag_z);
  modport dst (input tick, input mag_x, input mag_y, input mag_z);
endinterface

/* File: rtl/check_sampler.sv */
// rate divider and axis magnitude folding for the detector
`timescale 1ns/1ps
module check_sampler #(
  parameter int tick0 = ffmd_pkg::tick0_cycles,
  parameter int tick1 = ffmd_pkg::tick1_cycles,
  parameter int tick2 = ffmd_pkg::tick2_cycles,
  parameter int tick3 = ffmd_pkg::tick3_cycles
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // setup and samples
  input wire logic [1:0] rate_sel_in,
  input wire logic [11:0] x_in,
  input wire logic [11:0] y_in,
  input wire logic [11:0] z_in,
  // results
  axis_bus_if.src bus
);
  logic [19:0] div;
  logic [19:0] next_div;
  logic [19:0] limit;
  logic next_tick;
  logic [7:0] next_mx;
  logic [7:0] next_my;
  logic [7:0] next_mz;

  // fold a sample to distance from mid-scale, keep the upper eight bits
  function automatic logic [7:0] fold(input logic [11:0] s);
    logic [11:0] d;
    d = (s >= ffmd_pkg::mid_scale) ? s - ffmd_pkg::mid_scale : ffmd_pkg::mid_scale - s;
    if (d[11]) begin
      d = 12'h7ff;
    end
    // one step is 16 counts; the clamp keeps the deviation within seven step bits
    return {1'b0, d[10:4]};
  endfunction

  // divider; a rate change takes effect at once, a count already past the new limit wraps on the next edge
  always_comb begin
    unique case (rate_sel_in)
      2'b00: limit = 20'(tick0 - 1);
      2'b01: limit = 20'(tick1 - 1);
      2'b10: limit = 20'(tick2 - 1);
      2'b11: limit = 20'(tick3 - 1);
    endcase
    next_tick = (div >= limit);
    next_div = next_tick ? 20'h00000 : div + 20'h00001;
    next_mx = fold(x_in);
    next_my = fold(y_in);
    next_mz = fold(z_in);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      div <= 20'h00000;
      bus.tick <= 1'b0;
      bus.mag_x <= 8'h00;
      bus.mag_y <= 8'h00;
      bus.mag_z <= 8'h00;
    end else begin
      div <= next_div;
      bus.tick <= next_tick;
      bus.mag_x <= next_mx;
      bus.mag_y <= next_my;
      bus.mag_z <= next_mz;
    end
  end

  // a tick follows its wrap and never two back to back at these rates
  tick_spacing_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    bus.tick |=> !bus.tick) else $error("sample ticks back to back");
endmodule

/* File: rtl/ffmd_top.sv */
// free-fall and high-g motion detector with its two threshold and two debounce registers
`timescale 1ns/1ps
module ffmd_top #(
  parameter int tick0 = ffmd_pkg::tick0_cycles
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port from the serial front end
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // control bits from the control registers, and the asynchronous high-g enable pin
  input wire logic check_rate_sel_lo_in,
  input wire logic check_rate_sel_hi_in,
  input wire logic freefall_irq_enable_in,
  input wire logic freefall_latch_mode_in,
  input wire logic highg_latch_mode_in,
  input wire logic highg_enable_pin_in,
  // axis samples, 12 bits each
  input wire logic [11:0] x_in,
  input wire logic [11:0] y_in,
  input wire logic [11:0] z_in,
  // event outputs
  output logic freefall_out,
  output logic highg_out,
  output logic irq_out
);
  axis_bus_if ab ();

  logic [7:0] freefall_threshold;
  logic [7:0] freefall_debounce_count;
  logic [7:0] highg_threshold;
  logic [7:0] highg_debounce_count;
  logic [7:0] next_fft;
  logic [7:0] next_ffc;
  logic [7:0] next_hgt;
  logic [7:0] next_hgc;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [6:0] idx;
  logic [2:0] pin_sync;
  logic pin_level;
  logic next_pin_level;
  logic [8:0] ff_run;
  logic [8:0] hg_run;
  logic [8:0] next_ff_run;
  logic [8:0] next_hg_run;
  logic ff_cond;
  logic hg_cond;
  logic ff_det;
  logic hg_det;
  logic next_ff;
  logic next_hg;

  check_sampler #(.tick0(tick0)) sampler (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .rate_sel_in({check_rate_sel_hi_in, check_rate_sel_lo_in}),
    .x_in(x_in),
    .y_in(y_in),
    .z_in(z_in),
    .bus(ab)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register file; bit 7 of the address marks a read
  always_comb begin
    idx = reg_addr_in[6:0];
    next_fft = freefall_threshold;
    next_ffc = freefall_debounce_count;
    next_hgt = highg_threshold;
    next_hgc = highg_debounce_count;
    next_rdata = reg_rdata_out;
    next_rvalid = 1'b0;
    if (reg_wr_in && !reg_addr_in[ffmd_pkg::read_flag_bit]) begin
      unique case (idx)
        ffmd_pkg::addr_ff_thresh: next_fft = reg_wdata_in;
        ffmd_pkg::addr_ff_count: next_ffc = reg_wdata_in;
        ffmd_pkg::addr_hg_thresh: next_hgt = reg_wdata_in;
        ffmd_pkg::addr_hg_count: next_hgc = reg_wdata_in;
        default: ;
      endcase
    end
    if (reg_rd_in && reg_addr_in[ffmd_pkg::read_flag_bit]) begin
      next_rvalid = 1'b1;
      unique case (idx)
        ffmd_pkg::addr_ff_thresh: next_rdata = freefall_threshold;
        ffmd_pkg::addr_ff_count: next_rdata = freefall_debounce_count;
        ffmd_pkg::addr_hg_thresh: next_rdata = highg_threshold;
        ffmd_pkg::addr_hg_count: next_rdata = highg_debounce_count;
        default: next_rdata = 8'h00; // unmapped here, the front end owns the rest
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      freefall_threshold <= ffmd_pkg::rst_ff_thresh;
      freefall_debounce_count <= ffmd_pkg::rst_ff_count;
      highg_threshold <= ffmd_pkg::rst_hg_thresh;
      highg_debounce_count <= ffmd_pkg::rst_hg_count;
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      freefall_threshold <= next_fft;
      freefall_debounce_count <= next_ffc;
      highg_threshold <= next_hgt;
      highg_debounce_count <= next_hgc;
      reg_rdata_out <= next_rdata;
      reg_rvalid_out <= next_rvalid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable pin is asynchronous: three stages, a change counts once stages two and three agree
  always_comb begin
    next_pin_level = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_sync <= 3'b000;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], highg_enable_pin_in};
      pin_level <= next_pin_level;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // debounce: runs count passing samples; nine bits so a count of 255 still compares
  always_comb begin
    ff_cond = (ab.mag_x < freefall_threshold) && (ab.mag_y < freefall_threshold)
      && (ab.mag_z < freefall_threshold);
    hg_cond = (ab.mag_x > highg_threshold) || (ab.mag_y > highg_threshold)
      || (ab.mag_z > highg_threshold);
    next_ff_run = ff_run;
    next_hg_run = hg_run;
    if (ab.tick) begin
      next_ff_run = !ff_cond ? 9'h000 : (ff_run[8] ? ff_run : ff_run + 9'h001);
      next_hg_run = !hg_cond ? 9'h000 : (hg_run[8] ? hg_run : hg_run + 9'h001);
    end
    // a count of zero declares on the first passing sample
    ff_det = ff_cond && (next_ff_run >= {1'b0, freefall_debounce_count})
      && (next_ff_run != 9'h000);
    hg_det = hg_cond && (next_hg_run >= {1'b0, highg_debounce_count})
      && (next_hg_run != 9'h000);
    // latched outputs hold until their enable drops; the host must not enable mid-event
    if (!freefall_irq_enable_in) begin
      next_ff = 1'b0;
    end else if (freefall_latch_mode_in) begin
      next_ff = freefall_out | ff_det;
    end else begin
      next_ff = ff_det;
    end
    if (!pin_level) begin
      next_hg = 1'b0;
    end else if (highg_latch_mode_in) begin
      next_hg = highg_out | hg_det;
    end else begin
      next_hg = hg_det;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ff_run <= 9'h000;
      hg_run <= 9'h000;
      freefall_out <= 1'b0;
      highg_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      ff_run <= next_ff_run;
      hg_run <= next_hg_run;
      freefall_out <= next_ff;
      highg_out <= next_hg;
      irq_out <= next_ff | next_hg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  ff_enable_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !freefall_irq_enable_in |=> !freefall_out) else $error("free-fall while disabled");
  ff_latch_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    freefall_out && freefall_latch_mode_in && freefall_irq_enable_in |=> freefall_out)
    else $error("latched free-fall dropped");
  hg_latch_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    highg_out && highg_latch_mode_in && pin_level |=> highg_out)
    else $error("latched motion dropped");
  shared_irq_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    irq_out == (freefall_out || highg_out)) else $error("interrupt pin mismatch");
  ff_needs_cond_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(freefall_out) |-> $past(ff_cond)) else $error("free-fall without condition");
  hg_needs_cond_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(highg_out) |-> $past(hg_cond)) else $error("motion without condition");
  ff_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_wr_in && reg_addr_in == {1'b0, ffmd_pkg::addr_ff_thresh}
    |=> freefall_threshold == $past(reg_wdata_in)) else $error("threshold write lost");
  read_back_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_rd_in && reg_addr_in == {1'b1, ffmd_pkg::addr_hg_count}
    |=> reg_rvalid_out && reg_rdata_out == highg_debounce_count) else $error("bad read");
  run_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ab.tick && !hg_cond |=> hg_run == 0) else $error("count not restarted");
endmodule

/* File: verif/host_model.sv */
// host-side model issuing single-byte register reads and writes
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_in,
  // register strobes toward the detector
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  // read answer
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // write strobe held over one rising edge, then lines flipped so nothing stale lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // answer is taken half a cycle after the request edge, while rvalid stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    d = rdata_in;
    v = rvalid_in;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule

/* File: verif/ffmd_top_bench.sv */
// self-checking bench for the free-fall and high-g motion detector
`timescale 1ns/1ps
module ffmd_top_bench;
  localparam int tick = 40; // short check period keeps the run brief
  logic clk_in, resetn_in, wr, rd, rvalid, ffen, freefall_latch_mode, hglat, hgpin, ff, hg, irq;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] rsel;
  logic [11:0] x, y, z;
  int fails = 0;
  int checks = 0;
  int t;
  ffmd_top #(.tick0(tick)) ffmd_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .check_rate_sel_lo_in(rsel[0]),
    .check_rate_sel_hi_in(rsel[1]), .freefall_irq_enable_in(ffen),
    .freefall_latch_mode_in(freefall_latch_mode), .highg_latch_mode_in(hglat),
    .highg_enable_pin_in(hgpin), .x_in(x), .y_in(y), .z_in(z),
    .freefall_out(ff), .highg_out(hg), .irq_out(irq));
  host_model host_model_inst (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic vexp, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_model_inst.rd(a, d, v);
    chk1("read valid", vexp, v);
    if (vexp) chk8("read data", exp, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // bounded wait for free-fall (sel 0) or high-g (sel 1) to rise
  task automatic wait_up(input bit sel, input int n);
    t = 0;
    while ((sel ? hg : ff) !== 1'b1 && t < n) begin
      @(negedge clk_in);
      t++;
    end
    chk1(sel ? "highg rise" : "freefall rise", 1'b1, sel ? hg : ff);
    chk1("shared irq", 1'b1, irq);
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(8'h88, 1'b1, 8'h0e);
    rdchk(8'h89, 1'b1, 8'h01);
    rdchk(8'h8a, 1'b1, 8'h55);
    rdchk(8'h8b, 1'b1, 8'h01);
    rdchk(8'h8c, 1'b1, 8'h00);
    rdchk(8'h08, 1'b0, 8'h00);
    for (int i = 0; i < 4; i++) host_model_inst.wr(8'(8'h08 + i), 8'(8'ha5 ^ i));
    host_model_inst.wr(8'h89, 8'hff);
    for (int i = 0; i < 4; i++) rdchk(8'(8'h88 + i), 1'b1, 8'(8'ha5 ^ i));
    host_model_inst.wr(8'h08, 8'h0e);
    host_model_inst.wr(8'h09, 8'h03);
    host_model_inst.wr(8'h0a, 8'h55);
    host_model_inst.wr(8'h0b, 8'h02);
  endtask
  // three samples all below 14 steps; low nibble of each deviation from mid-scale is ignored
  task automatic t_ff_follow();
    ffen = 1'b1;
    cyc(2 * tick);
    x = 12'h8df;
    y = 12'h730;
    z = 12'h800;
    cyc(78);
    chk1("freefall early", 1'b0, ff);
    wait_up(1'b0, 50);
    x = 12'h8e0;
    cyc(3);
    chk1("freefall follow", 1'b0, ff);
    chk1("irq follow", 1'b0, irq);
  endtask
  task automatic t_ff_off();
    ffen = 1'b0;
    cyc(2);
    x = 12'h800;
    cyc(6 * tick);
    chk1("freefall disabled", 1'b0, ff);
    x = 12'h8e0;
    cyc(2 * tick);
  endtask
  task automatic t_ff_latch();
    freefall_latch_mode = 1'b1;
    ffen = 1'b1;
    cyc(2);
    x = 12'h800;
    wait_up(1'b0, 4 * tick);
    x = 12'h8e0;
    cyc(2 * tick);
    chk1("freefall latched", 1'b1, ff);
    ffen = 1'b0;
    cyc(3);
    chk1("freefall cleared", 1'b0, ff);
  endtask
  // 0x55 steps below mid-scale is not above threshold, 0x56 is
  task automatic t_highg();
    y = 12'h2b0;
    cyc(5 * tick);
    chk1("highg at threshold", 1'b0, hg);
    y = 12'h2a0;
    wait_up(1'b1, 3 * tick);
    y = 12'h800;
    cyc(3);
    chk1("highg follow", 1'b0, hg);
    hglat = 1'b1;
    cyc(2);
    z = 12'hd60;
    wait_up(1'b1, 3 * tick);
    z = 12'h800;
    cyc(2 * tick);
    chk1("highg latched", 1'b1, hg);
    hgpin = 1'b0;
    cyc(6);
    chk1("highg cleared", 1'b0, hg);
    chk1("irq cleared", 1'b0, irq);
  endtask
  // fastest rate select: two samples now span thousands of cycles, not tens
  task automatic t_rate();
    hglat = 1'b0;
    hgpin = 1'b1;
    rsel = 2'b11;
    cyc(ffmd_pkg::tick3_cycles + 50);
    y = 12'h2a0;
    cyc(ffmd_pkg::tick3_cycles - 10);
    chk1("highg slow rate", 1'b0, hg);
    wait_up(1'b1, ffmd_pkg::tick3_cycles + 50);
    y = 12'h800;
    cyc(3);
    chk1("highg slow drop", 1'b0, hg);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    fails++;
    $display("unexpected run time: expected finish, seen timeout");
    end_sim();
  end
  initial begin
    resetn_in = 1'b0;
    {ffen, freefall_latch_mode, hglat} = 3'h0;
    hgpin = 1'b1;
    rsel = 2'b00;
    x = 12'h8e0;
    y = 12'h800;
    z = 12'h800;
    cyc(2);
    resetn_in = 1'b1;
    chk1("freefall after reset", 1'b0, ff);
    t_regs();
    t_ff_follow();
    t_ff_off();
    t_ff_latch();
    t_highg();
    t_rate();
    end_sim();
  end
endmodule
